// ### verilog/pqc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef PQC_MAP_SVH
`define PQC_MAP_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PQC_OFS_CFG 8'h00
`define PQC_OFS_CTRL 8'h04
`define PQC_OFS_CMD 8'h08
`define PQC_OFS_STATE 8'h0c
`define PQC_OFS_FLAGS 8'h10
`define PQC_OFS_TOP 8'h14
`define PQC_OFS_COUNT 8'h18
`define PQC_OFS_OVS 8'h1c
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PQC_CFG_MODE 2:0
`define PQC_CFG_FILT 4
`define PQC_CTRL_DIR 0
`define PQC_CTRL_S1DIR 1
`define PQC_CTRL_INV 2
`define PQC_OVS_LEN 7:0
`define PQC_OVS_FLUT 12
`define PQC_CMD_START 0
`define PQC_CMD_STOP 1
`define PQC_ST_RUN 0
`define PQC_ST_DIR 1
`define PQC_FLG_UF 0
`define PQC_FLG_OF 1
`define PQC_FLG_DC 2
// ----------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------
`define PQC_CFG_RST 32'h0000_0000
`define PQC_CTRL_RST 32'h0000_0000
`define PQC_OVS_RST 32'h0000_0000
`define PQC_TOP_RST 16'hffff
`define PQC_CNT_RST 16'h0000
`define PQC_CFG_MASK 32'h0000_0017
`define PQC_CTRL_MASK 32'h0000_0007
`define PQC_OVS_MASK 32'h0000_10ff
// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define PQC_FILT_EXTRA 9'h005
`endif

// ### verilog/pqc_pkg.sv
// types shared by the pulse and quadrature counter
`default_nettype none
package pqc_pkg;
  // counting modes
  typedef enum logic [2:0] {
    PQC_SAMPLED_SINGLE = 3'b000,
    PQC_PIN_SINGLE = 3'b001,
    PQC_PIN_QUAD = 3'b010,
    PQC_QUAD_X1 = 3'b011,
    PQC_QUAD_X2 = 3'b100,
    PQC_QUAD_X4 = 3'b101
  } pqc_mode_t;
  // decoded software controls
  typedef struct packed {
    pqc_mode_t mode;
    logic filter_enable;
    logic count_direction_select;
    logic second_input_sets_direction;
    logic edge_invert;
    logic [7:0] filter_length;
    logic flutter_removal_enable;
  } pqc_ctrl_t;
endpackage
`default_nettype wire

// ### verilog/pqc_filter.sv
// input synchroniser and pulse-width filter for one count input
`include "pqc_map.svh"
`default_nettype none
module pqc_filter (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // pin and filter settings
  input wire logic pin_in,
  input wire logic filter_on_in,
  input wire logic [7:0] filter_length_in,
  // clean level
  output logic level_out
);
  logic s1, s2, s3, cand;
  logic [8:0] cnt;
  logic [8:0] lim;
  // ----------------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------------
  // RULE25: synchronise before edges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // a change counts only once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cand <= 1'b0;
    end else if (s2 == s3) begin
      cand <= s3;
    end
  end
  // ----------------------------------------------------------------------
  // pulse-width filter
  // ----------------------------------------------------------------------
  // RULE23: stable length plus five
  assign lim = {1'b0, filter_length_in} + `PQC_FILT_EXTRA - 9'h001;
  // stability counter, restarts whenever the candidate falls back
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 9'h000;
    end else if (!filter_on_in || cand == level_out) begin
      cnt <= 9'h000;
    end else begin
      cnt <= cnt + 9'h001;
    end
  end
  // RULE15: filtered level update
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_out <= 1'b0;
    end else if (cand != level_out && (!filter_on_in || cnt == lim)) begin
      level_out <= cand;
    end
  end
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_filter_hold: assert property ( // RULE23
    @(posedge clk_in) disable iff (!rst_n_in)
    filter_on_in && cand != level_out && cnt < lim |=> $stable(level_out))
    else $error("filtered level moved before stable length");
endmodule // pqc_filter
`default_nettype wire

// ### verilog/pqc_top.sv
// pulse counter and quadrature decoder with avalon-mm registers
`include "pqc_map.svh"
`default_nettype none
// ----------------------------------------------------------------------
// How it works
// RULE1: count lives in a 16-bit up/down counter readable by software
// RULE2: underflow and overflow set sticky event flags
// RULE3: counting runs only between start and stop commands
// RULE4: sampled single mode counts each detected edge of input a
// RULE5: source keeps input a at most half the sampling rate
// RULE6: invert control makes falling edges of input a count; pin clocked modes still count rising a
// RULE7: single modes count up, or down with direction select alone
// RULE8: with input b steering, b low reverses the chosen direction
// RULE9: pin clocked single counts rising edges of input a
// RULE10: pin clocked modes bypass the pulse-width filter
// RULE11: pin clocked quadrature samples b on both edges of a
// RULE12: exactly one b transition counts; rising gives direction one
// RULE13: a leading b decodes clockwise, a lagging counter-clockwise
// RULE14: quadrature direction is status; a change sets a flag
// RULE15: filter enable filters both inputs using the length field
// RULE16: x1 counts rising a going up, falling a going down
// RULE17: x2 counts both edges of a, x4 both edges of both
// RULE18: quadrature state is the pair b,a in gray order
// RULE19: clockwise steps add one per mode table
// RULE20: counter-clockwise steps subtract one per mode table
// RULE21: encoder toggles at most a quarter of the counter clock
// RULE22: flutter removal counts only repeated same-direction steps
// RULE23: filtered level must hold length plus five cycles
// RULE24: count wraps to zero above top, to top below zero
// RULE25: inputs pass a synchroniser before decoding
// ----------------------------------------------------------------------
module pqc_top
  import pqc_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // avalon-mm slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // encoder or sensor pins
  input wire logic count_input_a_in,
  input wire logic count_input_b_in
);
  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (COUNT_W < 2 || COUNT_W > 16) begin : g_bad_width
    $error("COUNT_W must lie in 2..16");
  end

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    lane_merge = r & m;
  endfunction

  // quadrature step, state pairs are {b, a}; result is {down, up}
  function automatic logic [1:0] quad_step(input logic [1:0] prv,
      input logic [1:0] nxt, input pqc_mode_t m);
    logic x2, x4;
    x4 = (m == PQC_QUAD_X4);
    x2 = (m == PQC_QUAD_X2) || x4;
    case ({prv, nxt})
      4'h1: quad_step = 2'b01;
      4'he: quad_step = {1'b0, x2};
      4'h7, 4'h8: quad_step = {1'b0, x4};
      4'h4: quad_step = 2'b10;
      4'hb: quad_step = {x2, 1'b0};
      4'hd, 4'h2: quad_step = {x4, 1'b0};
      default: quad_step = 2'b00;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [31:0] cfg_w, ctrl_w, ovs_w;
  pqc_ctrl_t ctl;
  logic [COUNT_W-1:0] count_value;
  logic [COUNT_W-1:0] top_value;
  logic [2:0] flags;
  logic running, dir_status, last_dir;
  logic a, b, pa, pb, b_at_fall;
  logic ae, be, pae, pbe;
  logic oversampled, quad_ovs;
  logic step_up, step_dn, quad_seen, quad_dir, quad_cnt;
  logic [1:0] qs;
  logic at_top, at_zero;
  logic req, bus_go, wr_go;
  logic cmd_start, cmd_stop;
  logic [2:0] flag_clr, flag_set;

  // ----------------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------------
  assign ctl.mode = pqc_mode_t'(cfg_w[`PQC_CFG_MODE]);
  assign ctl.filter_enable = cfg_w[`PQC_CFG_FILT];
  assign ctl.count_direction_select = ctrl_w[`PQC_CTRL_DIR];
  assign ctl.second_input_sets_direction = ctrl_w[`PQC_CTRL_S1DIR];
  assign ctl.edge_invert = ctrl_w[`PQC_CTRL_INV];
  assign ctl.filter_length = ovs_w[`PQC_OVS_LEN];
  assign ctl.flutter_removal_enable = ovs_w[`PQC_OVS_FLUT];
  assign oversampled = (ctl.mode == PQC_SAMPLED_SINGLE) || quad_ovs;
  assign quad_ovs = (ctl.mode == PQC_QUAD_X1) ||
                    (ctl.mode == PQC_QUAD_X2) || (ctl.mode == PQC_QUAD_X4);

  // ----------------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------------
  // RULE10: filter only in oversampled modes
  pqc_filter u_filt_a (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(count_input_a_in),
    .filter_on_in(ctl.filter_enable && oversampled),
    .filter_length_in(ctl.filter_length),
    .level_out(a)
  );
  pqc_filter u_filt_b (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(count_input_b_in),
    .filter_on_in(ctl.filter_enable && oversampled),
    .filter_length_in(ctl.filter_length),
    .level_out(b)
  );

  // previous levels for edge detection
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pa <= 1'b0;
      pb <= 1'b0;
    end else begin
      pa <= a;
      pb <= b;
    end
  end

  // RULE6: inversion; a in sampled single and x1/x2/x4, b also in pin single, none in pin quadrature
  always_comb begin
    ae = a ^ (ctl.edge_invert && ctl.mode != PQC_PIN_SINGLE &&
              ctl.mode != PQC_PIN_QUAD);
    pae = pa ^ (ctl.edge_invert && ctl.mode != PQC_PIN_SINGLE &&
                ctl.mode != PQC_PIN_QUAD);
    be = b ^ (ctl.edge_invert && ctl.mode != PQC_PIN_QUAD);
    pbe = pb ^ (ctl.edge_invert && ctl.mode != PQC_PIN_QUAD);
  end

  // b level caught at each falling edge of a in every mode, used in pin quadrature only
  // RULE11: sample b on both a edges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      b_at_fall <= 1'b0;
    end else if (pa && !a) begin
      b_at_fall <= b;
    end
  end

  // ----------------------------------------------------------------------
  // step decode
  // ----------------------------------------------------------------------
  assign qs = quad_step({pbe, pae}, {be, ae}, ctl.mode);
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    quad_seen = 1'b0;
    quad_dir = 1'b0;
    quad_cnt = 1'b0;
    case (ctl.mode)
      PQC_SAMPLED_SINGLE, PQC_PIN_SINGLE: begin
        // RULE4: count detected a edges
        // RULE9: rising a clocks the count
        if (ae && !pae) begin
          // RULE7: default up, select turns down
          // RULE8: b low reverses direction
          if (ctl.second_input_sets_direction && !be) begin
            step_up = ctl.count_direction_select;
          end else begin
            step_up = !ctl.count_direction_select;
          end
          step_dn = !step_up;
        end
      end
      PQC_PIN_QUAD: begin
        // RULE12: one b transition enables count
        if (a && !pa && (b != b_at_fall)) begin
          quad_seen = 1'b1;
          quad_dir = b;
          quad_cnt = 1'b1;
          step_up = b;
          step_dn = !b;
        end
      end
      PQC_QUAD_X1, PQC_QUAD_X2, PQC_QUAD_X4: begin
        // RULE16: x1 rise up, fall down
        // RULE17: x2 and x4 edge sets
        // RULE18: gray state pairs b,a
        // RULE19: clockwise add one
        // RULE20: counter-clockwise subtract one
        if (qs != 2'b00) begin
          quad_seen = 1'b1;
          // RULE13: a leading b is clockwise
          quad_dir = qs[0];
          // RULE22: flutter hold on reversal
          quad_cnt = !ctl.flutter_removal_enable || (qs[0] == last_dir);
          step_up = qs[0] && quad_cnt;
          step_dn = qs[1] && quad_cnt;
        end
      end
      default: begin
        step_up = 1'b0;
      end
    endcase
  end

  // direction of the last considered quadrature step
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_dir <= 1'b0;
    end else if (running && quad_seen) begin
      last_dir <= quad_dir;
    end
  end

  // RULE14: direction status in quadrature
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_status <= 1'b0;
    end else if (running && quad_seen && quad_cnt) begin
      dir_status <= quad_dir;
    end
  end

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  assign at_top = (count_value == top_value);
  assign at_zero = (count_value == '0);

  // RULE3: start and stop commands; stop wins if both
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      running <= 1'b0;
    end else if (cmd_stop) begin
      running <= 1'b0;
    end else if (cmd_start) begin
      running <= 1'b1;
    end
  end

  // RULE1: up/down count register
  // RULE24: wrap at top and zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_value <= COUNT_W'(`PQC_CNT_RST);
    end else if (running && step_up) begin
      count_value <= at_top ? '0 : count_value + 1'b1;
    end else if (running && step_dn) begin
      count_value <= at_zero ? top_value : count_value - 1'b1;
    end
  end

  // RULE2: wrap events set flags
  always_comb begin
    flag_set = 3'b000;
    flag_set[`PQC_FLG_UF] = running && step_dn && at_zero;
    flag_set[`PQC_FLG_OF] = running && step_up && at_top;
    flag_set[`PQC_FLG_DC] = running && quad_seen && quad_cnt &&
                            (quad_dir != dir_status);
  end

  // sticky flags, a set in the clearing cycle wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags <= 3'b000;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // ----------------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------------
  assign req = avs_read_in || avs_write_in;
  assign bus_go = req && !avs_waitrequest_out;
  assign wr_go = bus_go && avs_write_in;
  assign cmd_start = wr_go && avs_address_in == `PQC_OFS_CMD &&
                     avs_byteenable_in[0] &&
                     avs_writedata_in[`PQC_CMD_START];
  assign cmd_stop = wr_go && avs_address_in == `PQC_OFS_CMD &&
                    avs_byteenable_in[0] &&
                    avs_writedata_in[`PQC_CMD_STOP];
  assign flag_clr = (wr_go && avs_address_in == `PQC_OFS_FLAGS &&
                     avs_byteenable_in[0]) ? avs_writedata_in[2:0] : 3'b000;

  // one wait cycle per access; low for exactly one cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !(req && avs_waitrequest_out);
    end
  end

  // read data captured when the request is first seen
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      case (avs_address_in)
        `PQC_OFS_CFG: avs_readdata_out <= cfg_w;
        `PQC_OFS_CTRL: avs_readdata_out <= ctrl_w;
        `PQC_OFS_STATE: avs_readdata_out <= {30'h0, dir_status, running};
        `PQC_OFS_FLAGS: avs_readdata_out <= {29'h0, flags};
        `PQC_OFS_TOP: avs_readdata_out <= 32'(top_value);
        `PQC_OFS_COUNT: avs_readdata_out <= 32'(count_value);
        `PQC_OFS_OVS: avs_readdata_out <= ovs_w;
        default: avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // configuration words; unmapped writes are dropped
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_w <= `PQC_CFG_RST;
      ctrl_w <= `PQC_CTRL_RST;
      ovs_w <= `PQC_OVS_RST;
    end else if (wr_go) begin
      case (avs_address_in)
        `PQC_OFS_CFG: cfg_w <= lane_merge(cfg_w, avs_writedata_in,
            avs_byteenable_in, `PQC_CFG_MASK);
        `PQC_OFS_CTRL: ctrl_w <= lane_merge(ctrl_w, avs_writedata_in,
            avs_byteenable_in, `PQC_CTRL_MASK);
        `PQC_OFS_OVS: ovs_w <= lane_merge(ovs_w, avs_writedata_in,
            avs_byteenable_in, `PQC_OVS_MASK);
        default: cfg_w <= cfg_w;
      endcase
    end
  end

  // top value; software keeps count below a newly written top
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      top_value <= COUNT_W'(`PQC_TOP_RST);
    end else if (wr_go && avs_address_in == `PQC_OFS_TOP) begin
      top_value <= COUNT_W'(lane_merge(32'(top_value), avs_writedata_in,
          avs_byteenable_in, 32'h0000_ffff));
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_req_seen;
    req && avs_waitrequest_out;
  endsequence
  sequence s_one_wait;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence

  chk_bus_wait_one: assert property (s_req_seen |=> s_one_wait)
    else $error("waitrequest did not drop for exactly one cycle");
  chk_count_idle: assert property ( // RULE3
    !running |=> $stable(count_value))
    else $error("count moved while stopped");
  chk_count_inc: assert property ( // RULE1
    running && step_up && !at_top |=> count_value == $past(count_value) + 1'b1)
    else $error("count did not step up by one");
  chk_over_wrap: assert property ( // RULE24
    running && step_up && at_top |=> count_value == '0 && flags[1])
    else $error("overflow did not wrap to zero and flag");
  chk_under_wrap: assert property ( // RULE2
    running && step_dn && at_zero |=> count_value == $past(top_value) && flags[0])
    else $error("underflow did not wrap to top and flag");
  chk_single_edge: assert property ( // RULE4
    running && ctl.mode == PQC_SAMPLED_SINGLE && ae && !pae
    |=> count_value != $past(count_value))
    else $error("sampled single edge not counted");
  chk_dir_flag: assert property ( // RULE14
    running && quad_seen && quad_cnt && quad_dir != dir_status
    |=> flags[2] && dir_status == $past(quad_dir))
    else $error("direction change not reported");
  chk_flutter_hold: assert property ( // RULE22
    running && quad_ovs && ctl.flutter_removal_enable && quad_seen &&
    quad_dir != last_dir |=> $stable(count_value))
    else $error("flutter step changed the count");
  chk_x4_full: assert property ( // RULE19
    ctl.mode == PQC_QUAD_X4 && {pbe, pae} == 2'b01 && {be, ae} == 2'b11
    |-> qs == 2'b01)
    else $error("x4 clockwise step not decoded");
endmodule // pqc_top
`default_nettype wire

// ### tb/pqc_encoder.sv
// rotary encoder model driving both count inputs in gray order
`default_nettype none
module pqc_encoder (
  // clock
  input wire logic clk_in,
  // encoder phases
  output logic a_out,
  output logic b_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // shaft position
  // ----------------------------------------------------------------
  logic [1:0] ph = 2'b00;
  assign b_out = ph[1];
  assign a_out = ph[1] ^ ph[0];
  // one step, held four cycles so that no line toggles too fast
  // toggle spacing
  task automatic step(input logic cw);
    @(posedge clk_in);
    ph <= cw ? ph + 2'h1 : ph - 2'h1;
    // a pulse of two steps spans eight cycles, the 160 ns link period
    repeat (3) @(posedge clk_in);
  endtask
endmodule // pqc_encoder
`default_nettype wire

// ### tb/pqc_top_test.sv
// self-checking bench for the pulse and quadrature counter
`include "pqc_map.svh"
`default_nettype none
module pqc_top_test
  import pqc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic a;
  logic b;
  logic [31:0] exp_q[$];
  logic [15:0] cnt;
  integer seed = 32'h6dff8a0c;
  int fails = 0;
  int comparisons = 0;
  int n;
  always #10 clk_in = ~clk_in;
  pqc_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .count_input_a_in(a), .count_input_b_in(b));
  pqc_encoder enc (.clk_in(clk_in), .a_out(a), .b_out(b));
  // ----------------------------------------------------------------
  // read answers, compared in request order
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rd && wreq === 1'b0) begin
      comparisons++;
      if (rdata !== exp_q[0]) begin
        fails++;
        $display("wrong value at %0t: read %h not %h", $time, rdata,
          exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end
  // one bus access; a read notes its expected word
  task automatic bus(input logic w, input logic [7:0] ad,
      input logic [31:0] d);
    @(posedge clk_in);
    addr <= ad;
    wdata <= d;
    if (w) begin
      wr <= 1'b1;
    end else begin
      rd <= 1'b1;
      exp_q.push_back(d);
    end
    // hold everything until a rising edge sees waitrequest low
    do @(posedge clk_in); while (wreq !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // k moves; alt makes single pulses on a with b low
  task automatic move(input int k, input logic cw, input logic alt);
    repeat (k) begin
      enc.step(cw);
      if (alt) enc.step(!cw);
    end
    repeat (10) @(posedge clk_in);
  endtask
  task automatic chk();
    bus(0, `PQC_OFS_COUNT, {16'h0, cnt});
  endtask
  task automatic tally_and_finish();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    cnt = 16'h0;
    bus(0, `PQC_OFS_CFG, 32'h0);
    bus(0, `PQC_OFS_TOP, 32'hffff);
    bus(0, 8'h20, 32'h0);
    move(2, 1, 1);
    chk();
    bus(1, `PQC_OFS_CMD, 32'h1);
    bus(0, `PQC_OFS_STATE, 32'h1);
    n = ($random(seed) & 3) + 1;
    move(n, 1, 1);
    cnt = n;
    chk();
    bus(1, `PQC_OFS_CTRL, 32'h1);
    move(1, 1, 1);
    cnt--;
    chk();
    bus(1, `PQC_OFS_CTRL, 32'h3);
    move(1, 1, 1);
    cnt++;
    chk();
    // inverted b reads high, so the steered count goes up again
    bus(1, `PQC_OFS_CTRL, 32'h6);
    move(1, 1, 1);
    cnt++;
    chk();
    bus(1, `PQC_OFS_CTRL, 32'h0);
    bus(1, `PQC_OFS_CFG, 32'h1);
    move(2, 1, 1);
    cnt += 2;
    chk();
    // filter bit has no effect when the pin clocks the count
    bus(1, `PQC_OFS_CFG, 32'h11);
    move(1, 1, 1);
    cnt++;
    chk();
    // a four cycle pulse is shorter than length zero plus five
    bus(1, `PQC_OFS_CFG, 32'h10);
    move(1, 1, 1);
    chk();
    // pin quadrature: b seen at a rise against b at the last fall
    bus(1, `PQC_OFS_CFG, 32'h2);
    move(8, 1, 0);
    cnt--;
    chk();
    move(8, 0, 0);
    cnt++;
    chk();
    bus(0, `PQC_OFS_STATE, 32'h3);
    // one full turn each way in x1, x2 and x4
    for (int m = 3; m < 6; m++) begin
      bus(1, `PQC_OFS_CFG, m);
      move(4, 1, 0);
      cnt += 16'h1 << (m - 3);
      chk();
      bus(0, `PQC_OFS_STATE, 32'h3);
      move(4, 0, 0);
      cnt -= 16'h1 << (m - 3);
      chk();
      bus(0, `PQC_OFS_STATE, 32'h1);
    end
    bus(0, `PQC_OFS_FLAGS, 32'h4);
    // first reversed step is dropped with flutter removal
    bus(1, `PQC_OFS_OVS, 32'h1000);
    move(2, 1, 0);
    cnt++;
    chk();
    move(2, 0, 0);
    cnt--;
    chk();
    bus(1, `PQC_OFS_OVS, 32'h0);
    bus(1, `PQC_OFS_FLAGS, 32'h7);
    cnt = cnt + 16'h1;
    bus(1, `PQC_OFS_TOP, {16'h0, cnt});
    move(2, 1, 0);
    cnt = 16'h0;
    chk();
    bus(0, `PQC_OFS_FLAGS, 32'h6);
    bus(1, `PQC_OFS_FLAGS, 32'h7);
    bus(0, `PQC_OFS_FLAGS, 32'h0);
    move(1, 0, 0);
    bus(0, `PQC_OFS_FLAGS, 32'h5);
    bus(1, `PQC_OFS_CMD, 32'h2);
    move(2, 1, 0);
    bus(0, `PQC_OFS_STATE, 32'h0);
    tally_and_finish();
  end
  // hang guard, far beyond the roughly seven hundred cycles needed
  initial begin
    repeat (40000) @(posedge clk_in);
    fails++;
    tally_and_finish();
  end
endmodule // pqc_top_test
`default_nettype wire
